// ==== dmi_pkg.sv ====
package dmi_pkg;
    // core sizes
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int WORD_W = 16;
    localparam int NUM_PTR = 3;

    // quarter phases of one instruction cycle
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;

    // opcode prefixes, compared under the masks below
    localparam logic [15:0] MASK_MOVE = 16'hFC00;
    localparam logic [15:0] CODE_MOVE = 16'h5000;
    localparam logic [15:0] MASK_STORE = 16'hFE00;
    localparam logic [15:0] CODE_STORE = 16'h6E00;
    localparam logic [15:0] MASK_BYTE = 16'hFF00;
    localparam logic [15:0] CODE_BANK = 16'h0100;
    localparam logic [15:0] CODE_WLIT = 16'h0E00;
    localparam logic [15:0] MASK_MEM = 16'hF000;
    localparam logic [15:0] CODE_MEM = 16'hC000;
    localparam logic [15:0] MASK_PTR = 16'hFFC0;
    localparam logic [15:0] CODE_PTR = 16'hEE00;

    // operand fields
    localparam int BIT_DEST = 9;
    localparam int BIT_BANK = 8;
    localparam int PTR_SEL_LSB = 4;
    localparam logic [1:0] PTR_SEL_MAX = 2'h2;

    // addressing
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] INDEXED_MAX = 8'h5F;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [11:0] W_ADDR = 12'hFE8;

    // register map, byte offsets
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_WORK = 5'h04;
    localparam logic [4:0] REG_BANK = 5'h08;
    localparam logic [4:0] REG_STAT = 5'h0C;
    localparam logic [4:0] REG_PTR0 = 5'h10;
    localparam logic [4:0] REG_PTR1 = 5'h14;
    localparam logic [4:0] REG_PTR2 = 5'h18;

    // status and control bits
    localparam int ST_ZERO = 0;
    localparam int ST_NEG = 1;
    localparam int ST_UNKNOWN = 2;
    localparam int ST_SECOND = 3;
    localparam int CTRL_EXT = 0;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [11:0] RST_PTR = 12'h000;
    localparam logic [3:0] RST_BANK = 4'h0;

    typedef enum logic [1:0] {
        DMI_ST_FIRST = 2'b01,
        DMI_ST_SECOND = 2'b10
    } dmi_state_t;

    typedef enum logic [6:0] {
        DMI_OP_NOP = 7'b0000001,
        DMI_OP_PTR = 7'b0000010,
        DMI_OP_MOVE = 7'b0000100,
        DMI_OP_MEM = 7'b0001000,
        DMI_OP_BANK = 7'b0010000,
        DMI_OP_WLIT = 7'b0100000,
        DMI_OP_STORE = 7'b1000000
    } dmi_op_t;
endpackage

// ==== dmi_addr_if.sv ====
`timescale 1ns/1ps
// operand address forming between the core and the address former
interface dmi_addr_if;
    logic [7:0] file;
    logic bank_bit;
    logic [3:0] bank;
    logic [11:0] ptr2;
    logic ext_en;
    logic [11:0] addr;
    modport requester (output file, bank_bit, bank, ptr2, ext_en, input addr);
    modport former (input file, bank_bit, bank, ptr2, ext_en, output addr);
endinterface

// ==== dmi_addr_form.sv ====
`timescale 1ns/1ps
module dmi_addr_form (
    // request and formed address
    dmi_addr_if.former port
);
    // bank bit and extended mode choose the data address
    always_comb begin
        if (port.bank_bit) begin
            port.addr = {port.bank, port.file}; // [RULE6]
        end else if (port.ext_en && (port.file <= dmi_pkg::INDEXED_MAX)) begin
            port.addr = port.ptr2 + {4'h0, port.file}; // [RULE7]
        end else if (port.file < dmi_pkg::ACCESS_SPLIT) begin
            port.addr = {dmi_pkg::ACCESS_LO_BANK, port.file}; // [RULE6]
        end else begin
            port.addr = {dmi_pkg::ACCESS_HI_BANK, port.file}; // [RULE6]
        end
    end
endmodule

// ==== dmi_core.sv ====
`timescale 1ns/1ps
// What this block does
// RULE1: pointer load puts 12-bit literal in pointer 0-2
// RULE2: pointer high part first cycle, low byte second
// RULE3: register move copies file register in one cycle
// RULE4: dest bit 0 writes W, 1 writes back
// RULE5: register move sets N and Z only
// RULE6: bank bit 0 access bank, 1 bank register
// RULE7: extended mode, bank 0, f<=95 indexed
// RULE8: memory move is two words, two cycles
// RULE9: memory move spans 4096 bytes, no flags
// RULE10: memory move may use W either side
// RULE11: software avoids counter low and stack tops
// RULE12: bank load takes literal low nibble, no flags
// RULE13: literal load into W, no flags
// RULE14: store copies W to file register, no flags
// RULE15: operand read Q2, result written Q4
module dmi_core #(
    parameter int ADDR_W = dmi_pkg::ADDR_W,
    parameter int DATA_W = dmi_pkg::DATA_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register bus
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // instruction fetch
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    output logic instr_ready,
    // data memory
    output logic [11:0] mem_addr,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    // status
    output logic instr_unknown
);
    // decoder assumes 12-bit addresses and bytes
    if (ADDR_W != 12 || DATA_W != 8) begin : g_bad_width
        $error("dmi_core supports only 12-bit address and 8-bit data");
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode
    function automatic dmi_pkg::dmi_op_t dmi_decode(input logic [15:0] w);
        if ((w & dmi_pkg::MASK_MOVE) == dmi_pkg::CODE_MOVE) begin
            dmi_decode = dmi_pkg::DMI_OP_MOVE; // [RULE3]
        end else if ((w & dmi_pkg::MASK_STORE) == dmi_pkg::CODE_STORE) begin
            dmi_decode = dmi_pkg::DMI_OP_STORE; // [RULE14]
        end else if ((w & dmi_pkg::MASK_BYTE) == dmi_pkg::CODE_BANK) begin
            dmi_decode = dmi_pkg::DMI_OP_BANK; // [RULE12]
        end else if ((w & dmi_pkg::MASK_BYTE) == dmi_pkg::CODE_WLIT) begin
            dmi_decode = dmi_pkg::DMI_OP_WLIT; // [RULE13]
        end else if ((w & dmi_pkg::MASK_MEM) == dmi_pkg::CODE_MEM) begin
            dmi_decode = dmi_pkg::DMI_OP_MEM; // [RULE8]
        end else if ((w & dmi_pkg::MASK_PTR) == dmi_pkg::CODE_PTR) begin
            dmi_decode = dmi_pkg::DMI_OP_PTR; // [RULE1]
        end else begin
            dmi_decode = dmi_pkg::DMI_OP_NOP;
        end
    endfunction

    logic [1:0] q_reg;
    dmi_pkg::dmi_state_t state_reg;
    dmi_pkg::dmi_op_t op_reg;
    dmi_pkg::dmi_op_t dec;
    logic [15:0] ir_reg;
    logic go_reg;
    logic [7:0] data_reg;
    logic [7:0] w_reg;
    logic [3:0] bsr_reg;
    logic [11:0] ptr_reg [dmi_pkg::NUM_PTR];
    logic n_reg;
    logic z_reg;
    logic ext_reg;
    logic take;
    logic to_w;
    logic [7:0] src;
    logic sw_wr;
    logic sw_rd;
    logic [1:0] sel;

    dmi_addr_if aif ();

    dmi_addr_form u_addr (
        .port(aif.former)
    );

    // operand address comes straight from the word being taken
    assign aif.file = instr_word[7:0];
    assign aif.bank_bit = instr_word[dmi_pkg::BIT_BANK];
    assign aif.bank = bsr_reg;
    assign aif.ptr2 = ptr_reg[2];
    assign aif.ext_en = ext_reg;

    assign dec = dmi_decode(instr_word);
    assign take = (q_reg == dmi_pkg::PH_Q1) && instr_valid && instr_ready;
    assign to_w = (mem_addr == dmi_pkg::W_ADDR); // [RULE10]
    assign src = to_w ? w_reg : mem_rdata; // [RULE10]
    assign sw_wr = avs_write && !avs_waitrequest;
    assign sw_rd = avs_read && avs_waitrequest;

    ////////////////////////////////////////////////////////////////////////////
    // quarter phase divider; Q1 is the only fetch slot
    always_ff @(posedge clock) begin
        if (rst) begin
            q_reg <= dmi_pkg::PH_Q1;
            instr_ready <= 1'b0;
        end else begin
            q_reg <= q_reg + 2'h1;
            instr_ready <= (q_reg == dmi_pkg::PH_Q4);
        end
    end

    // instruction capture and two-word sequencing
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= dmi_pkg::DMI_ST_FIRST;
            op_reg <= dmi_pkg::DMI_OP_NOP;
            ir_reg <= 16'h0000;
            go_reg <= 1'b0;
        end else if (q_reg == dmi_pkg::PH_Q1) begin
            if (state_reg == dmi_pkg::DMI_ST_FIRST) begin
                op_reg <= take ? dec : dmi_pkg::DMI_OP_NOP;
                go_reg <= take;
                if (take) begin
                    ir_reg <= instr_word;
                    sel <= instr_word[dmi_pkg::PTR_SEL_LSB +: 2]; // [RULE2]
                end
            end else begin
                // a missing second word stalls a whole cycle, op is kept
                go_reg <= take;
                if (take) begin
                    ir_reg <= instr_word;
                end
            end
        end else if (q_reg == dmi_pkg::PH_Q4) begin
            case (state_reg)
                dmi_pkg::DMI_ST_FIRST: begin
                    if (op_reg == dmi_pkg::DMI_OP_PTR || op_reg == dmi_pkg::DMI_OP_MEM) begin
                        state_reg <= dmi_pkg::DMI_ST_SECOND; // [RULE8]
                    end
                end
                dmi_pkg::DMI_ST_SECOND: begin
                    if (go_reg) begin
                        state_reg <= dmi_pkg::DMI_ST_FIRST;
                        op_reg <= dmi_pkg::DMI_OP_NOP;
                    end
                end
                default: state_reg <= dmi_pkg::DMI_ST_FIRST;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data memory: address and read in Q2, write in Q4
    always_ff @(posedge clock) begin
        if (rst) begin
            mem_addr <= 12'h000;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_wdata <= dmi_pkg::RST_BYTE;
        end else begin
            case (q_reg)
                dmi_pkg::PH_Q1: begin
                    if (take && state_reg == dmi_pkg::DMI_ST_SECOND) begin
                        mem_addr <= instr_word[11:0]; // [RULE9]
                    end else if (take && dec == dmi_pkg::DMI_OP_MEM) begin
                        mem_addr <= instr_word[11:0]; // [RULE9]
                        mem_rd <= 1'b1; // [RULE15]
                    end else if (take && dec == dmi_pkg::DMI_OP_MOVE) begin
                        mem_addr <= aif.addr; // [RULE6]
                        mem_rd <= 1'b1; // [RULE15]
                    end else if (take && dec == dmi_pkg::DMI_OP_STORE) begin
                        mem_addr <= aif.addr; // [RULE6]
                    end
                end
                dmi_pkg::PH_Q2: begin
                    mem_rd <= 1'b0;
                end
                dmi_pkg::PH_Q3: begin
                    // writes aimed at W stay inside the block
                    if (!to_w && go_reg) begin
                        if (state_reg == dmi_pkg::DMI_ST_SECOND) begin
                            if (op_reg == dmi_pkg::DMI_OP_MEM) begin
                                mem_wr <= 1'b1; // [RULE8] [RULE15] [RULE11]
                                mem_wdata <= data_reg;
                            end
                        end else if (op_reg == dmi_pkg::DMI_OP_MOVE
                                     && ir_reg[dmi_pkg::BIT_DEST]) begin
                            mem_wr <= 1'b1; // [RULE4] [RULE15]
                            mem_wdata <= src;
                        end else if (op_reg == dmi_pkg::DMI_OP_STORE) begin
                            mem_wr <= 1'b1; // [RULE14] [RULE15]
                            mem_wdata <= w_reg;
                        end
                    end
                end
                default: begin
                    mem_wr <= 1'b0;
                end
            endcase
        end
    end

    // operand latch; survives into the second cycle of the memory move
    always_ff @(posedge clock) begin
        if (rst) begin
            data_reg <= dmi_pkg::RST_BYTE;
        end else if (q_reg == dmi_pkg::PH_Q3 && state_reg == dmi_pkg::DMI_ST_FIRST
                     && (op_reg == dmi_pkg::DMI_OP_MOVE || op_reg == dmi_pkg::DMI_OP_MEM)) begin
            data_reg <= src; // [RULE15] [RULE10]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // working register; the core wins over a bus write in the same edge
    always_ff @(posedge clock) begin
        if (rst) begin
            w_reg <= dmi_pkg::RST_BYTE;
        end else if (q_reg == dmi_pkg::PH_Q4 && go_reg
                     && state_reg == dmi_pkg::DMI_ST_FIRST
                     && op_reg == dmi_pkg::DMI_OP_MOVE
                     && (!ir_reg[dmi_pkg::BIT_DEST] || to_w)) begin
            w_reg <= data_reg; // [RULE4]
        end else if (q_reg == dmi_pkg::PH_Q4 && go_reg
                     && state_reg == dmi_pkg::DMI_ST_FIRST
                     && op_reg == dmi_pkg::DMI_OP_WLIT) begin
            w_reg <= ir_reg[7:0]; // [RULE13]
        end else if (q_reg == dmi_pkg::PH_Q4 && go_reg
                     && state_reg == dmi_pkg::DMI_ST_SECOND
                     && op_reg == dmi_pkg::DMI_OP_MEM && to_w) begin
            w_reg <= data_reg; // [RULE10]
        end else if (sw_wr && avs_address == dmi_pkg::REG_WORK && avs_byteenable[0]) begin
            w_reg <= avs_writedata[7:0];
        end
    end

    // negative and zero flags follow only the register move
    always_ff @(posedge clock) begin
        if (rst) begin
            n_reg <= 1'b0;
            z_reg <= 1'b0;
        end else if (q_reg == dmi_pkg::PH_Q4 && go_reg
                     && state_reg == dmi_pkg::DMI_ST_FIRST
                     && op_reg == dmi_pkg::DMI_OP_MOVE) begin
            n_reg <= data_reg[7]; // [RULE5]
            z_reg <= (data_reg == 8'h00); // [RULE5]
        end else if (sw_wr && avs_address == dmi_pkg::REG_STAT && avs_byteenable[0]) begin
            n_reg <= avs_writedata[dmi_pkg::ST_NEG];
            z_reg <= avs_writedata[dmi_pkg::ST_ZERO];
        end
    end

    // bank select register, low nibble only
    always_ff @(posedge clock) begin
        if (rst) begin
            bsr_reg <= dmi_pkg::RST_BANK;
        end else if (q_reg == dmi_pkg::PH_Q4 && go_reg
                     && state_reg == dmi_pkg::DMI_ST_FIRST
                     && op_reg == dmi_pkg::DMI_OP_BANK) begin
            bsr_reg <= ir_reg[3:0]; // [RULE12]
        end else if (sw_wr && avs_address == dmi_pkg::REG_BANK && avs_byteenable[0]) begin
            bsr_reg <= avs_writedata[3:0];
        end
    end

    // indirect pointers; selector 3 is refused and writes nothing
    for (genvar i = 0; i < dmi_pkg::NUM_PTR; i++) begin : g_ptr
        always_ff @(posedge clock) begin
            if (rst) begin
                ptr_reg[i] <= dmi_pkg::RST_PTR;
            end else if (q_reg == dmi_pkg::PH_Q4 && op_reg == dmi_pkg::DMI_OP_PTR
                         && sel == 2'(i) && sel <= dmi_pkg::PTR_SEL_MAX && go_reg
                         && state_reg == dmi_pkg::DMI_ST_FIRST) begin
                ptr_reg[i][11:8] <= ir_reg[3:0]; // [RULE1] [RULE2]
            end else if (q_reg == dmi_pkg::PH_Q4 && op_reg == dmi_pkg::DMI_OP_PTR
                         && sel == 2'(i) && go_reg
                         && state_reg == dmi_pkg::DMI_ST_SECOND) begin
                ptr_reg[i][7:0] <= ir_reg[7:0]; // [RULE2]
            end else if (sw_wr && avs_address == dmi_pkg::REG_PTR0 + 5'(4 * i)) begin
                if (avs_byteenable[0]) begin
                    ptr_reg[i][7:0] <= avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    ptr_reg[i][11:8] <= avs_writedata[11:8];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control and sticky unknown-opcode flag; set wins over clear
    always_ff @(posedge clock) begin
        if (rst) begin
            ext_reg <= 1'b0;
            instr_unknown <= 1'b0;
        end else begin
            if (sw_wr && avs_address == dmi_pkg::REG_CTRL && avs_byteenable[0]) begin
                ext_reg <= avs_writedata[dmi_pkg::CTRL_EXT]; // steers [RULE7]
            end
            if (take && state_reg == dmi_pkg::DMI_ST_FIRST && dec == dmi_pkg::DMI_OP_NOP) begin
                instr_unknown <= 1'b1;
            end else if (sw_wr && avs_address == dmi_pkg::REG_STAT && avs_byteenable[0]
                         && avs_writedata[dmi_pkg::ST_UNKNOWN]) begin
                instr_unknown <= 1'b0;
            end
        end
    end

    // bus slave: one wait cycle, answer on the second edge
    always_ff @(posedge clock) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (sw_rd) begin
                case (avs_address)
                    dmi_pkg::REG_CTRL: avs_readdata <= {31'h0, ext_reg};
                    dmi_pkg::REG_WORK: avs_readdata <= {24'h0, w_reg};
                    dmi_pkg::REG_BANK: avs_readdata <= {28'h0, bsr_reg};
                    dmi_pkg::REG_STAT: begin
                        avs_readdata <= {28'h0, state_reg == dmi_pkg::DMI_ST_SECOND,
                                         instr_unknown, n_reg, z_reg};
                    end
                    dmi_pkg::REG_PTR0: avs_readdata <= {20'h0, ptr_reg[0]};
                    dmi_pkg::REG_PTR1: avs_readdata <= {20'h0, ptr_reg[1]};
                    dmi_pkg::REG_PTR2: avs_readdata <= {20'h0, ptr_reg[2]};
                    default: avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// ==== dmi_core_asserts.sv ====
`timescale 1ns/1ps
module dmi_core_asserts (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register bus
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // instruction stream
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic instr_ready,
    // data memory and status
    input wire logic [11:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic instr_unknown
);
    // one domain, so clock and disable are given once
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    logic take;
    // a word is taken at the edge that ends the fetch phase
    assign take = instr_ready && instr_valid;
    ////////////////////////////////////////////////////////////////////////
    chk_ready_cycle: assert property (instr_ready |=> !instr_ready[*3] ##1 instr_ready)
        else $error("fetch phase is not one clock in four");
    chk_read_phase: assert property (mem_rd |-> $past(take))
        else $error("operand read outside the second phase");
    chk_write_phase: assert property (mem_wr |-> $past(instr_ready, 3))
        else $error("result write outside the fourth phase");
    chk_idle_quiet: assert property (instr_ready && !instr_valid
        |=> !mem_rd ##2 !mem_wr)
        else $error("memory touched in an idle or stalled cycle");
    chk_src_read: assert property (take
        && ((instr_word & dmi_pkg::MASK_MEM) == dmi_pkg::CODE_MEM)
        |=> mem_rd && (mem_addr == $past(instr_word[11:0])) ##4 !mem_rd)
        else $error("memory move source read wrong");
    chk_bank_addr: assert property (take
        && ((instr_word & dmi_pkg::MASK_MOVE) == dmi_pkg::CODE_MOVE) && instr_word[8]
        |=> mem_rd && (mem_addr[7:0] == $past(instr_word[7:0])))
        else $error("register move address wrong");
    chk_wr_hold: assert property (mem_wr |-> $stable(mem_addr))
        else $error("address moved under a write");
    chk_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    chk_flag_clear: assert property ($fell(instr_unknown)
        |-> $past(avs_write) && ($past(avs_address) == dmi_pkg::REG_STAT))
        else $error("unknown flag dropped without a status write");
endmodule
bind dmi_core dmi_core_asserts chk (.clock, .rst, .avs_address, .avs_read, .avs_write,
    .avs_waitrequest, .instr_word, .instr_valid, .instr_ready, .mem_addr, .mem_rd, .mem_wr,
    .instr_unknown);

// ==== dmi_mem_model.sv ====
`timescale 1ns/1ps
module dmi_mem_model (
    // clock
    input wire logic clock,
    // data memory port
    input wire logic [11:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] store [4096];
    logic [11:0] last_rd = 12'h000;
    logic [11:0] last_wr = 12'h000;
    int wr_count = 0;
    initial mem_rdata = 8'h00;
    ////////////////////////////////////////////////////////////////////////
    // data stands one cycle after the strobe, then toggles so late samples fail
    always @(posedge clock) begin
        if (mem_rd) begin
            mem_rdata <= store[mem_addr];
            last_rd <= mem_addr;
        end else begin
            mem_rdata <= ~mem_rdata;
        end
        if (mem_wr) begin
            store[mem_addr] <= mem_wdata;
            last_wr <= mem_addr;
            wr_count <= wr_count + 1;
        end
    end
endmodule

// ==== dmi_core_test.sv ====
`timescale 1ns/1ps
module dmi_core_test;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [15:0] instr_word = 16'h0000;
    logic instr_valid = 1'b0;
    logic instr_ready;
    logic [11:0] mem_addr;
    logic mem_rd;
    logic [7:0] mem_rdata;
    logic mem_wr;
    logic [7:0] mem_wdata;
    logic instr_unknown;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////////
    dmi_core uut (.clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .instr_word, .instr_valid,
        .instr_ready, .mem_addr, .mem_rd, .mem_rdata, .mem_wr, .mem_wdata, .instr_unknown);
    dmi_mem_model mem (.clock, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
    always #10 clock = ~clock;
    // a hang ends here, far above the run's length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request held until waitrequest is seen low, then released
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask
    task automatic mem_chk(input logic [11:0] a, input logic [7:0] exp);
        check({24'h0, mem.store[a]}, {24'h0, exp});
    endtask
    // valid stays up between words so two-word pairs go back to back
    task automatic issue(input logic [15:0] w);
        @(posedge clock);
        instr_word <= w;
        instr_valid <= 1'b1;
        do @(posedge clock); while (instr_ready !== 1'b1);
    endtask
    task automatic settle;
        @(posedge clock);
        instr_valid <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    task automatic run(input logic [15:0] w);
        issue(w);
        settle();
    endtask
    task automatic run2(input logic [15:0] a, input logic [15:0] b);
        issue(a);
        issue(b);
        settle();
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd_chk(dmi_pkg::REG_WORK, 32'h0);
        rd_chk(dmi_pkg::REG_BANK, 32'h0);
        rd_chk(dmi_pkg::REG_STAT, 32'h0);
        wr(5'h1C, 32'hFF);
        rd_chk(5'h1C, 32'h0);
        $display("test reset done");
    endtask
    // second word is withheld while the pointer is read: the slot stalls
    task automatic t_ptr;
        logic [11:0] k;
        for (int s = 0; s < 3; s++) begin
            k = (s == 0) ? 12'hFFF : (s == 1) ? 12'h801 : 12'h3AB;
            run(16'hEE00 | 16'(s << 4) | {12'h000, k[11:8]});
            rd_chk(5'(dmi_pkg::REG_PTR0 + 4 * s), {20'h0, k[11:8], 8'h00});
            run({8'hF0, k[7:0]});
            rd_chk(5'(dmi_pkg::REG_PTR0 + 4 * s), {20'h0, k});
        end
        run(16'hEE31);
        run(16'hF022);
        rd_chk(dmi_pkg::REG_PTR2, 32'h3AB);
        $display("test pointer load done");
    endtask
    task automatic t_move;
        wr(dmi_pkg::REG_STAT, 32'h3);
        wr(dmi_pkg::REG_WORK, 32'hFF);
        mem.store[12'h022] = 8'h22;
        run(16'h5022);
        rd_chk(dmi_pkg::REG_WORK, 32'h22);
        check({20'h0, mem.last_rd}, 32'h022);
        rd_chk(dmi_pkg::REG_STAT, 32'h0);
        wr(dmi_pkg::REG_BANK, 32'h5);
        mem.store[12'h510] = 8'h80;
        run(16'h5310);
        check({20'h0, mem.last_wr}, 32'h510);
        mem_chk(12'h510, 8'h80);
        rd_chk(dmi_pkg::REG_WORK, 32'h22);
        rd_chk(dmi_pkg::REG_STAT, 32'h2);
        mem.store[12'hF70] = 8'h00;
        run(16'h5070);
        rd_chk(dmi_pkg::REG_WORK, 32'h0);
        check({20'h0, mem.last_rd}, 32'hF70);
        rd_chk(dmi_pkg::REG_STAT, 32'h1);
        $display("test register move done");
    endtask
    task automatic t_ext;
        wr(dmi_pkg::REG_CTRL, 32'h1);
        wr(dmi_pkg::REG_PTR2, 32'h200);
        mem.store[12'h205] = 8'h5A;
        run(16'h5005);
        rd_chk(dmi_pkg::REG_WORK, 32'h5A);
        check({20'h0, mem.last_rd}, 32'h205);
        mem.store[12'hF60] = 8'h11;
        run(16'h5060);
        check({20'h0, mem.last_rd}, 32'hF60);
        wr(dmi_pkg::REG_CTRL, 32'h0);
        $display("test indexed mode done");
    endtask
    // destinations stay clear of the counter low byte and stack tops
    task automatic t_mem;
        int c;
        wr(dmi_pkg::REG_STAT, 32'h3);
        mem.store[12'hFFF] = 8'h33;
        c = mem.wr_count;
        run2(16'hCFFF, 16'hF000);
        mem_chk(12'h000, 8'h33);
        check(32'(mem.wr_count - c), 32'h1);
        rd_chk(dmi_pkg::REG_STAT, 32'h3);
        wr(dmi_pkg::REG_WORK, 32'h4F);
        run2(16'hCFE8, 16'hF123);
        mem_chk(12'h123, 8'h4F);
        mem.store[12'h456] = 8'h66;
        run2(16'hC456, 16'hFFE8);
        rd_chk(dmi_pkg::REG_WORK, 32'h66);
        $display("test memory move done");
    endtask
    task automatic t_lit;
        wr(dmi_pkg::REG_STAT, 32'h3);
        run(16'h01A7);
        rd_chk(dmi_pkg::REG_BANK, 32'h7);
        run(16'h0E5A);
        rd_chk(dmi_pkg::REG_WORK, 32'h5A);
        run(16'h6F33);
        mem_chk(12'h733, 8'h5A);
        rd_chk(dmi_pkg::REG_STAT, 32'h3);
        $display("test literal and store done");
    endtask
    task automatic t_unk;
        run(16'h1234);
        rd_chk(dmi_pkg::REG_STAT, 32'h7);
        wr(dmi_pkg::REG_STAT, 32'h7);
        rd_chk(dmi_pkg::REG_STAT, 32'h3);
        $display("test unknown word done");
    endtask
    task results;
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_ptr();
        t_move();
        t_ext();
        t_mem();
        t_lit();
        t_unk();
        results();
    end
endmodule
